/* pkg/ebr_defines.svh */
// register offsets, field positions and reset values of the event buffer
// readout block; included by the package user files, holds defines only
`ifndef EBR_DEFINES_SVH
`define EBR_DEFINES_SVH

`define EBR_OFF_CTRL 8'h00
`define EBR_OFF_COUNT 8'h04
`define EBR_OFF_PTRS 8'h08
`define EBR_OFF_STAT 8'h0C
`define EBR_OFF_NTA 8'h10
`define EBR_OFF_SCAN 8'h14
`define EBR_OFF_BLK 8'h18
`define EBR_OFF_RND 8'h1C

`define EBR_CTRL_TEST 0
`define EBR_CTRL_PRIME 1
`define EBR_CTRL_CHAIN 2
`define EBR_CTRL_PRIMARY 3
`define EBR_CTRL_END 4
`define EBR_CTRL_ADV 8

`define EBR_PTR_RD_LSB 0
`define EBR_PTR_WP_LSB 8

`define EBR_STAT_EMPTY 0
`define EBR_STAT_FULL 1
`define EBR_STAT_BUSY 2
`define EBR_STAT_CNT_LSB 8

`define EBR_RST_RDPG 6'h3F
`define EBR_RST_WP 6'h00
`define EBR_RST_WOFF 11'h001
`define EBR_PRIME_DEPTH 11'h002

`endif

/* pkg/ebr_pkg.sv */
// types shared by the event buffer readout design
// assumes ebr_defines.svh is compiled alongside
package ebr_pkg;
    typedef enum logic {
        EBR_ST_IDLE = 1'b0,
        EBR_ST_ANS = 1'b1
    } ebr_phase_e;

    typedef enum logic [7:0] {
        EBR_SCAN_SPARSE = 8'h09,
        EBR_SCAN_AVAIL = 8'h19,
        EBR_SCAN_HDR_ONLY = 8'hCD
    } ebr_scan_e;
endpackage : ebr_pkg

/* src/ebr_page_mem.sv */
// paged event memory: one write port, two asynchronous read ports
// assumes a single clock; contents are data and carry no reset
`timescale 1ns/1ps
`default_nettype none
module ebr_page_mem #(
    parameter int ADDR_BITS = 17,
    parameter int DATA_W = 32
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [ADDR_BITS-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [ADDR_BITS-1:0] raddr_a,
    output logic [DATA_W-1:0] rdata_a,
    input wire logic [ADDR_BITS-1:0] raddr_b,
    output logic [DATA_W-1:0] rdata_b
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_BITS)-1];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
endmodule : ebr_page_mem
`default_nettype wire

/* src/ebr_scan.sv */
// broadcast scan decoder: answers whether the T pin is to be asserted
// assumes the caller latches the answer when the code is written
`timescale 1ns/1ps
`default_nettype none
module ebr_scan import ebr_pkg::*; (
    input wire logic [7:0] code,
    input wire logic empty,
    input wire logic count_is_one,
    output logic hit,
    output logic known
);
    wire logic is_sparse = (code == EBR_SCAN_SPARSE);
    wire logic is_avail = (code == EBR_SCAN_AVAIL);
    wire logic is_hdr = (code == EBR_SCAN_HDR_ONLY);

    assign hit = (is_sparse & !empty)
        | (is_avail & empty)
        | (is_hdr & count_is_one);
    assign known = is_sparse | is_avail | is_hdr;
endmodule : ebr_scan
`default_nettype wire

/* src/ebr_readout_top.sv */
// event buffer readout: APB register slave, paged circular buffer,
// advance command, block reads and broadcast scans
// assumes front end words arrive synchronous to pclk, end pulse apart
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ebr_defines.svh"
module ebr_readout_top import ebr_pkg::*; #(
    parameter int PAGE_BITS = 6,
    parameter int OFF_BITS = 11
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ev_word_valid,
    input wire logic [31:0] ev_word_data,
    input wire logic ev_end,
    input wire logic ev_discard,
    output logic conversion_in_progress,
    output logic buffer_full,
    output logic t_pin,
    input wire logic chain_token_in,
    output logic chain_token_out
);
    localparam int ADDR_BITS = PAGE_BITS + OFF_BITS;
    localparam logic [OFF_BITS-1:0] OFF_ZERO = '0;

    ebr_phase_e phase;
    logic [PAGE_BITS-1:0] read_page;
    logic [PAGE_BITS-1:0] write_page;
    logic [OFF_BITS-1:0] read_page_offset;
    logic [OFF_BITS-1:0] write_page_offset;
    logic [OFF_BITS-1:0] block_word_counter;
    logic memory_test_mode;
    logic prime_en;
    logic chain_en;
    logic chain_primary;
    logic chain_end;
    logic primed;
    logic token;
    logic ev_active;

    // empty and full come from the page distance alone
    wire logic [PAGE_BITS-1:0] rdpg_plus1 = PAGE_BITS'(read_page + 1'b1);
    wire logic [PAGE_BITS-1:0] wp_plus1 = PAGE_BITS'(write_page + 1'b1);
    wire logic empty = (write_page == rdpg_plus1);
    wire logic full = (write_page == read_page);
    wire logic [PAGE_BITS-1:0] ev_count =
        PAGE_BITS'(write_page - rdpg_plus1);

    wire logic sel_ctrl = (paddr == `EBR_OFF_CTRL);
    wire logic sel_count = (paddr == `EBR_OFF_COUNT);
    wire logic sel_ptrs = (paddr == `EBR_OFF_PTRS);
    wire logic sel_stat = (paddr == `EBR_OFF_STAT);
    wire logic sel_nta = (paddr == `EBR_OFF_NTA);
    wire logic sel_scan = (paddr == `EBR_OFF_SCAN);
    wire logic sel_blk = (paddr == `EBR_OFF_BLK);
    wire logic sel_rnd = (paddr == `EBR_OFF_RND);
    wire logic sel_any = sel_ctrl | sel_count | sel_ptrs | sel_stat
        | sel_nta | sel_scan | sel_blk | sel_rnd;

    // a test-mode memory write shares the port with the front end, so
    // it waits while the front end writes rather than lose a word
    wire logic ev_port_busy = ev_word_valid | ev_end;
    wire logic rnd_wr_req = pwrite & sel_rnd & memory_test_mode;
    wire logic do_acc = psel & penable & (phase == EBR_ST_IDLE)
        & !(rnd_wr_req & ev_port_busy);
    wire logic wr = do_acc & pwrite;
    wire logic rd = do_acc & !pwrite;

    wire logic adv_cmd = wr & sel_ctrl & pwdata[`EBR_CTRL_ADV];
    wire logic adv_ok = adv_cmd & !empty;
    wire logic my_turn = !chain_en | token;
    wire logic cnt_zero = (block_word_counter == OFF_ZERO);
    wire logic blk_rd = rd & sel_blk & my_turn;
    wire logic blk_go = blk_rd & !cnt_zero;
    wire logic ss2 = blk_rd & cnt_zero & (!chain_en | chain_end);
    wire logic blk_wr_err = wr & sel_blk;
    wire logic rnd_wr = wr & sel_rnd & memory_test_mode;
    wire logic pass_turn = blk_go & chain_en & !chain_end
        & (block_word_counter == OFF_BITS'(1));
    wire logic nta_wr = wr & sel_nta & memory_test_mode;

    // front end stores nothing while full
    wire logic ev_hdr = ev_end & !full;
    wire logic ev_wr = ev_word_valid & !full & !ev_end;

    // header: page and one-past-last offset, so null gives count 1
    wire logic [31:0] hdr_word =
        {(32 - ADDR_BITS)'(0), write_page, write_page_offset};
    wire logic mem_we = ev_hdr | ev_wr | rnd_wr;
    wire logic [ADDR_BITS-1:0] mem_waddr = ev_hdr ? {write_page, OFF_ZERO}
        : ev_wr ? {write_page, write_page_offset}
        : {read_page, read_page_offset};
    wire logic [31:0] mem_wdata = ev_hdr ? hdr_word
        : ev_wr ? ev_word_data : pwdata;
    wire logic [31:0] cur_word;
    wire logic [31:0] next_hdr;

    ebr_page_mem #(
        .ADDR_BITS(ADDR_BITS),
        .DATA_W(32)
    ) u_mem (
        .pclk(pclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a({read_page, read_page_offset}),
        .rdata_a(cur_word),
        .raddr_b({rdpg_plus1, OFF_ZERO}),
        .rdata_b(next_hdr)
    );

    wire logic scan_hit;
    wire logic scan_known;

    ebr_scan u_scan (
        .code(pwdata[7:0]),
        .empty(empty),
        .count_is_one(block_word_counter == OFF_BITS'(1)),
        .hit(scan_hit),
        .known(scan_known)
    );

    // primed pipeline shows the next address two words ahead of the read offset
    wire logic [OFF_BITS-1:0] nta_view = primed
        ? OFF_BITS'(read_page_offset + `EBR_PRIME_DEPTH)
        : read_page_offset;
    wire logic [31:0] ctrl_view = 32'(
        {chain_end, chain_primary, chain_en, prime_en, memory_test_mode});
    wire logic [31:0] ptr_view =
        (32'(write_page) << `EBR_PTR_WP_LSB)
        | (32'(read_page) << `EBR_PTR_RD_LSB);
    wire logic [31:0] stat_view = (32'(ev_count) << `EBR_STAT_CNT_LSB)
        | (32'(conversion_in_progress) << `EBR_STAT_BUSY)
        | (32'(full) << `EBR_STAT_FULL)
        | (32'(empty) << `EBR_STAT_EMPTY);
    // register reads depend on the pipeline state only in the next address view
    wire logic [31:0] rd_mux = sel_ctrl ? ctrl_view
        : sel_count ? 32'(block_word_counter)
        : sel_ptrs ? ptr_view
        : sel_stat ? stat_view
        : sel_nta ? (memory_test_mode ? 32'(nta_view) : 32'h0000_0000)
        : sel_scan ? 32'(t_pin)
        : (sel_blk & blk_go) ? cur_word
        : sel_rnd ? cur_word
        : 32'h0000_0000;
    wire logic err_now = ss2 | blk_wr_err | !sel_any;

    assign pready = (phase == EBR_ST_ANS);
    assign buffer_full = full;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= EBR_ST_IDLE;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            phase <= do_acc ? EBR_ST_ANS : EBR_ST_IDLE;
            if (do_acc) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= err_now;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            memory_test_mode <= 1'b0;
            prime_en <= 1'b0;
            chain_en <= 1'b0;
            chain_primary <= 1'b0;
            chain_end <= 1'b0;
        end else if (wr & sel_ctrl) begin
            memory_test_mode <= pwdata[`EBR_CTRL_TEST];
            prime_en <= pwdata[`EBR_CTRL_PRIME];
            chain_en <= pwdata[`EBR_CTRL_CHAIN];
            chain_primary <= pwdata[`EBR_CTRL_PRIMARY];
            chain_end <= pwdata[`EBR_CTRL_END];
        end
    end

    // read side: one access per transfer, so these never collide;
    // an early stop simply leaves offset and counter where they are
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_page_offset <= OFF_ZERO;
            block_word_counter <= OFF_ZERO;
            primed <= 1'b0;
        end else if (adv_ok) begin
            read_page_offset <= OFF_ZERO;
            block_word_counter <= next_hdr[OFF_BITS-1:0];
            primed <= prime_en & memory_test_mode;
        end else if (blk_go) begin
            read_page_offset <= OFF_BITS'(read_page_offset + 1'b1);
            block_word_counter <= OFF_BITS'(block_word_counter - 1'b1);
        end else if (nta_wr) begin
            read_page_offset <= pwdata[OFF_BITS-1:0];
            primed <= 1'b0;
        end else if (wr & sel_count) begin
            block_word_counter <= pwdata[OFF_BITS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_page <= `EBR_RST_RDPG;
        end else if (adv_ok) begin
            read_page <= rdpg_plus1;
        end else if (wr & sel_ptrs) begin
            read_page <= pwdata[`EBR_PTR_RD_LSB +: PAGE_BITS];
        end
    end

    // front end wins over a software pointer write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_page <= `EBR_RST_WP;
            write_page_offset <= `EBR_RST_WOFF;
            ev_active <= 1'b0;
        end else if (ev_discard) begin
            write_page_offset <= `EBR_RST_WOFF;
            ev_active <= 1'b0;
        end else if (ev_hdr) begin
            write_page <= wp_plus1;
            write_page_offset <= `EBR_RST_WOFF;
            ev_active <= 1'b0;
        end else if (ev_wr) begin
            write_page_offset <= OFF_BITS'(write_page_offset + 1'b1);
            ev_active <= 1'b1;
        end else if (wr & sel_ptrs) begin
            write_page <= pwdata[`EBR_PTR_WP_LSB +: PAGE_BITS];
        end
    end

    // busy flag also follows the full state, cleared by an advance, or a cycle after a pointer write ends it
    wire logic next_full = adv_ok ? 1'b0 : (ev_hdr ? (wp_plus1 == read_page)
        : full);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_in_progress <= 1'b0;
        end else begin
            conversion_in_progress <= next_full | (ev_wr & !ev_discard)
                | (ev_active & !ev_hdr & !ev_discard);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_pin <= 1'b0;
        end else if (wr & sel_scan & scan_known) begin
            t_pin <= scan_hit;
        end
    end

    // the turn is taken by the token input or by arming a primary link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            token <= 1'b0;
            chain_token_out <= 1'b0;
        end else begin
            chain_token_out <= pass_turn;
            if (chain_token_in | (wr & sel_ctrl & pwdata[`EBR_CTRL_CHAIN]
                & pwdata[`EBR_CTRL_PRIMARY])) begin
                token <= 1'b1;
            end else if (pass_turn) begin
                token <= 1'b0;
            end
        end
    end

    sequence s_adv_req;
        adv_ok;
    endsequence
    sequence s_adv_done(logic [PAGE_BITS-1:0] pg, logic [OFF_BITS-1:0] c);
        (read_page == pg) && (read_page_offset == OFF_ZERO)
            && (block_word_counter == c);
    endsequence

    property p_blk_step;
        @(posedge pclk) disable iff (!presetn)
        blk_go |=> read_page_offset == OFF_BITS'($past(read_page_offset) + 1'b1)
            && block_word_counter == OFF_BITS'($past(block_word_counter) - 1'b1);
    endproperty
    a_blk_step: assert property (p_blk_step)
        else $error("block read did not step offset and counter");

    property p_rnd_hold;
        @(posedge pclk) disable iff (!presetn)
        (rd & sel_rnd) |=> $stable(read_page_offset);
    endproperty
    a_rnd_hold: assert property (p_rnd_hold)
        else $error("random read moved the offset");

    property p_blk_wr;
        @(posedge pclk) disable iff (!presetn)
        blk_wr_err |=> pready && pslverr;
    endproperty
    a_blk_wr: assert property (p_blk_wr)
        else $error("block write not refused");

    property p_ss2;
        @(posedge pclk) disable iff (!presetn)
        (rd & sel_blk & cnt_zero & !chain_en) |=> pready && pslverr
            && $stable(read_page_offset);
    endproperty
    a_ss2: assert property (p_ss2)
        else $error("exhausted counter did not end the block read");

    property p_adv;
        logic [PAGE_BITS-1:0] pg;
        logic [OFF_BITS-1:0] c;
        @(posedge pclk) disable iff (!presetn)
        (s_adv_req, pg = rdpg_plus1, c = next_hdr[OFF_BITS-1:0])
            |=> s_adv_done(pg, c);
    endproperty
    a_adv: assert property (p_adv)
        else $error("advance did not load page, offset and counter");

    property p_adv_empty;
        @(posedge pclk) disable iff (!presetn)
        (adv_cmd & empty) |=> $stable(read_page) && $stable(block_word_counter);
    endproperty
    a_adv_empty: assert property (p_adv_empty)
        else $error("advance on empty buffer changed state");

    property p_full_hold;
        @(posedge pclk) disable iff (!presetn)
        (full & !adv_ok) |=> conversion_in_progress;
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("busy dropped while buffer full");

    property p_full_store;
        @(posedge pclk) disable iff (!presetn)
        (full & !(wr & sel_ptrs)) |=> $stable(write_page);
    endproperty
    a_full_store: assert property (p_full_store)
        else $error("event stored while buffer full");

    property p_avail_scan;
        @(posedge pclk) disable iff (!presetn)
        (wr & sel_scan & pwdata[7:0] == 8'h19) |=> t_pin == $past(empty);
    endproperty
    a_avail_scan: assert property (p_avail_scan)
        else $error("available scan answer wrong");

    property p_nta_ignore;
        @(posedge pclk) disable iff (!presetn)
        (wr & sel_nta & !memory_test_mode) |=> $stable(read_page_offset)
            ##1 $stable(read_page_offset) [*1];
    endproperty
    a_nta_ignore: assert property (p_nta_ignore)
        else $error("default mode next address write took effect");
endmodule : ebr_readout_top
`default_nettype wire

/* dv/ebr_fe_model.sv */
// front end event source feeding words and end pulses to the readout
// assumes one clock; one word a cycle, end pulse a cycle after the last
`timescale 1ns/1ps
`default_nettype none
module ebr_fe_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [7:0] n_words,
    output logic ev_word_valid,
    output logic [31:0] ev_word_data,
    output logic ev_end,
    output logic ev_discard,
    output logic busy
);
    logic [7:0] left;
    logic [7:0] idx;
    // fast clear is outside what this bench exercises
    assign ev_discard = 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            left <= 8'h00;
            idx <= 8'h00;
            ev_word_valid <= 1'b0;
            ev_word_data <= 32'h00000000;
            ev_end <= 1'b0;
        end else begin
            ev_word_valid <= 1'b0;
            ev_end <= 1'b0;
            // idle data toggles so a stale word never passes as fresh
            ev_word_data <= ~ev_word_data;
            if (start && !busy) begin
                busy <= 1'b1;
                left <= n_words;
                idx <= 8'h01;
            end else if (busy && left != 8'h00) begin
                ev_word_valid <= 1'b1;
                ev_word_data <= {24'hDA7A00, idx};
                idx <= idx + 8'h01;
                left <= left - 8'h01;
            end else if (busy) begin
                ev_end <= 1'b1;
                busy <= 1'b0;
            end
        end
    end
endmodule : ebr_fe_model
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench: apb master tasks, front end model, chain token
// assumes the readout top with default parameters and its defines header
`timescale 1ns/1ps
`default_nettype none
`include "ebr_defines.svh"
module tb_top;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr, fe_n;
    logic [31:0] pwdata, prdata, ev_word_data, rdat;
    logic pready, pslverr, ev_word_valid, ev_end, ev_discard, rerr;
    logic conversion_in_progress, buffer_full, t_pin, fe_start, fe_busy;
    logic chain_token_in, chain_token_out, tok_seen;
    int errors, samples_checked;
    ebr_readout_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ev_word_valid(ev_word_valid), .ev_word_data(ev_word_data),
        .ev_end(ev_end), .ev_discard(ev_discard),
        .conversion_in_progress(conversion_in_progress),
        .buffer_full(buffer_full), .t_pin(t_pin),
        .chain_token_in(chain_token_in), .chain_token_out(chain_token_out));
    ebr_fe_model fe (.pclk(pclk), .presetn(presetn), .start(fe_start),
        .n_words(fe_n), .ev_word_valid(ev_word_valid),
        .ev_word_data(ev_word_data), .ev_end(ev_end),
        .ev_discard(ev_discard), .busy(fe_busy));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (chain_token_out === 1'b1) tok_seen <= 1'b1;
    end
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string what);
        apb(1'b0, a, 32'h0);
        chk(what, e, rdat);
    endtask : rdc
    task automatic errc(input logic e);
        chk("pslverr", {31'h0, e}, {31'h0, rerr});
    endtask : errc
    task automatic ev(input logic [7:0] n);
        int k;
        k = 0;
        @(posedge pclk);
        fe_n <= n;
        fe_start <= 1'b1;
        @(posedge pclk);
        fe_start <= 1'b0;
        @(posedge pclk);
        while (fe_busy !== 1'b0 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        repeat (2) @(posedge pclk);
    endtask : ev
    task automatic adv(input logic [31:0] mode);
        apb(1'b1, `EBR_OFF_CTRL, 32'h100 | mode);
    endtask : adv
    task automatic tok;
        @(posedge pclk);
        chain_token_in <= 1'b1;
        @(posedge pclk);
        chain_token_in <= 1'b0;
    endtask : tok
    task automatic scan(input logic [7:0] c, input logic e);
        apb(1'b1, `EBR_OFF_SCAN, {24'h0, c});
        chk("t_pin", {31'h0, e}, {31'h0, t_pin});
    endtask : scan
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        conclude();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, fe_start, chain_token_in} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        fe_n = 8'h00;
        tok_seen = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`EBR_OFF_PTRS, 32'h3F, "ptrs");
        rdc(`EBR_OFF_STAT, 32'h1, "status");
        scan(8'h19, 1'b1);
        scan(8'h09, 1'b0);
        apb(1'b1, `EBR_OFF_COUNT, 32'h7F);
        adv(32'h0);
        rdc(`EBR_OFF_PTRS, 32'h3F, "ptrs");
        rdc(`EBR_OFF_COUNT, 32'h7F, "count");
        apb(1'b0, 8'h20, 32'h0);
        errc(1'b1);
        apb(1'b1, `EBR_OFF_BLK, 32'h1);
        errc(1'b1);
        $display("reset and empty test done");
        ev(8'h03);
        scan(8'h09, 1'b1);
        scan(8'h19, 1'b0);
        adv(32'h0);
        rdc(`EBR_OFF_PTRS, 32'h0100, "ptrs");
        rdc(`EBR_OFF_COUNT, 32'h4, "count");
        apb(1'b0, `EBR_OFF_BLK, 32'h0);
        chk("header", 32'h4, rdat & 32'h1FFFF);
        for (int i = 1; i < 4; i++) begin
            rdc(`EBR_OFF_BLK, {24'hDA7A00, 8'(i)}, "word");
        end
        apb(1'b0, `EBR_OFF_BLK, 32'h0);
        errc(1'b1);
        rdc(`EBR_OFF_COUNT, 32'h0, "count");
        ev(8'h00);
        adv(32'h0);
        rdc(`EBR_OFF_COUNT, 32'h1, "count");
        scan(8'hCD, 1'b1);
        apb(1'b0, `EBR_OFF_BLK, 32'h0);
        chk("header", 32'h801, rdat & 32'h1FFFF);
        rdc(`EBR_OFF_NTA, 32'h0, "nta");
        apb(1'b1, `EBR_OFF_NTA, 32'h5);
        errc(1'b0);
        $display("block read test done");
        apb(1'b1, `EBR_OFF_CTRL, 32'h1);
        apb(1'b1, `EBR_OFF_NTA, 32'hFFFFF7FE);
        rdc(`EBR_OFF_PTRS, 32'h0201, "ptrs");
        rdc(`EBR_OFF_NTA, 32'h7FE, "nta");
        for (int j = 0; j < 3; j++) begin
            apb(1'b1, `EBR_OFF_NTA, (32'h7FE + j) & 32'h7FF);
            apb(1'b1, `EBR_OFF_RND, 32'hC0DE0000 + j);
        end
        apb(1'b1, `EBR_OFF_NTA, 32'h7FE);
        apb(1'b1, `EBR_OFF_COUNT, 32'h3);
        for (int j = 0; j < 3; j++) begin
            rdc(`EBR_OFF_BLK, 32'hC0DE0000 + j, "word");
        end
        rdc(`EBR_OFF_NTA, 32'h1, "nta");
        apb(1'b0, `EBR_OFF_RND, 32'h0);
        rdc(`EBR_OFF_NTA, 32'h1, "nta");
        ev(8'h02);
        apb(1'b1, `EBR_OFF_CTRL, 32'h3);
        adv(32'h3);
        rdc(`EBR_OFF_NTA, 32'h2, "nta");
        rdc(`EBR_OFF_COUNT, 32'h3, "count");
        rdc(`EBR_OFF_PTRS, 32'h0302, "ptrs");
        apb(1'b1, `EBR_OFF_CTRL, 32'h0);
        $display("memory test mode test done");
        for (int k = 0; k < 62; k++) ev(8'h00);
        chk("full", 32'h0, {31'h0, buffer_full});
        ev(8'h00);
        chk("full", 32'h1, {31'h0, buffer_full});
        rdc(`EBR_OFF_STAT, 32'h3F06, "status");
        ev(8'h02);
        chk("busy", 32'h1, {31'h0, conversion_in_progress});
        rdc(`EBR_OFF_PTRS, 32'h0202, "ptrs");
        adv(32'h0);
        chk("full", 32'h0, {31'h0, buffer_full});
        chk("busy", 32'h0, {31'h0, conversion_in_progress});
        rdc(`EBR_OFF_COUNT, 32'h1, "count");
        $display("full buffer test done");
        adv(32'h14);
        rdc(`EBR_OFF_BLK, 32'h0, "idle link");
        errc(1'b0);
        rdc(`EBR_OFF_COUNT, 32'h1, "count");
        tok();
        apb(1'b0, `EBR_OFF_BLK, 32'h0);
        chk("header", 32'h2001, rdat & 32'h1FFFF);
        apb(1'b0, `EBR_OFF_BLK, 32'h0);
        errc(1'b1);
        adv(32'h04);
        tok();
        apb(1'b0, `EBR_OFF_BLK, 32'h0);
        chk("header", 32'h2801, rdat & 32'h1FFFF);
        repeat (3) @(posedge pclk);
        chk("token out", 32'h1, {31'h0, tok_seen});
        $display("chained read test done");
        apb(1'b1, `EBR_OFF_PTRS, 32'h0203);
        adv(32'h0);
        rdc(`EBR_OFF_COUNT, 32'h1, "count");
        rdc(`EBR_OFF_BLK, 32'h2001, "header");
        $display("reread test done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
